/* src/acgt_pkg.sv */
package acgt_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_AXES      = 2;
	localparam int NUM_STEPS     = 150;
	localparam int NUM_ITEMS     = 16;
	localparam int NUM_TEACH     = 16;
	localparam int NUM_PARAMS    = 16;
	localparam int DATA_W        = 32;
	localparam int STEP_W        = 8;
	localparam int ITEM_W        = 5;
	// ****************************************
	// Error codes
	// ****************************************
	localparam logic [15:0] ERR_NONE       = 16'h0000;
	localparam logic [15:0] ERR_INCHING_MOVE_CMD_BUSY  = 16'h0191;
	localparam logic [15:0] ERR_PARAM_BUSY = 16'h01d7;
	localparam logic [15:0] ERR_OPD_BUSY   = 16'h01d8;
	localparam logic [15:0] ERR_TPOS_BUSY  = 16'h01cd;
	localparam logic [15:0] ERR_TSPD_BUSY  = 16'h01cf;
	localparam logic [15:0] ERR_AXIS       = 16'h0006;
	localparam logic [15:0] ERR_RANGE      = 16'h0007;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [11:0] OFS_CMD        = 12'h000;
	localparam logic [11:0] OFS_ARG0       = 12'h004;
	localparam logic [11:0] OFS_ARG1       = 12'h008;
	localparam logic [11:0] OFS_DATA       = 12'h00c;
	localparam logic [11:0] OFS_STATUS0    = 12'h010;
	localparam logic [11:0] OFS_STATUS1    = 12'h014;
	localparam logic [11:0] OFS_MOTION     = 12'h018;
	localparam logic [11:0] OFS_INCH0      = 12'h01c;
	localparam logic [11:0] OFS_INCH1      = 12'h020;
	localparam logic [11:0] OFS_TEACH_BASE = 12'h100;
	localparam logic [11:0] OFS_RD_DATA    = 12'h024;
	localparam logic [11:0] OFS_NV_COUNT   = 12'h028;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CMD_OP_LSB     = 0;
	localparam int CMD_AXIS_BIT   = 4;
	localparam int CMD_ITEM_LSB   = 8;
	localparam int CMD_STEP_LSB   = 16;
	localparam int ARG_CNT_LSB    = 0;
	localparam int ARG_FIRST_LSB  = 8;
	localparam int ARG_TARGET_BIT = 16;
	localparam int ARG_METHOD_BIT = 17;
	localparam int ST_ERRFLAG_BIT = 16;
	localparam int ST_OPER_BIT    = 17;
	localparam int ST_INCHING_MOVE_CMD_BIT    = 18;
	// ****************************************
	// Items and opcodes
	// ****************************************
	localparam logic [4:0] ITEM_POSITION = 5'h01;
	localparam logic [4:0] ITEM_SPEED    = 5'h03;
	localparam logic [3:0] OP_NONE       = 4'h0;
	localparam logic [3:0] OP_INCHING_MOVE_CMD       = 4'h1;
	localparam logic [3:0] OP_BASIC      = 4'h2;
	localparam logic [3:0] OP_HOMEMAN    = 4'h3;
	localparam logic [3:0] OP_COMMON     = 4'h4;
	localparam logic [3:0] OP_OPDATA     = 4'h5;
	localparam logic [3:0] OP_TEACH      = 4'h6;
	localparam logic [3:0] OP_CLR_ERR    = 4'h7;
	localparam logic [3:0] OP_READ       = 4'h8;
endpackage

/* src/acgt_mem_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface acgt_mem_if #(parameter int AW = 13, parameter int DW = 32);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* src/acgt_opdata_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module acgt_opdata_mem #(
	parameter int DEPTH = 4800,
	parameter int AW    = 13,
	parameter int DW    = 32
) (
	input  wire logic core_clk,
	acgt_mem_if.mem   port
);
	logic [DW-1:0] mem_q [DEPTH];
	logic [DW-1:0] rdata_reg;

	if (DEPTH > (1 << AW)) begin : g_bad_depth
		$error("depth exceeds address width");
	end

	always_ff @(posedge core_clk) begin
		if (port.we)
			mem_q[port.waddr] <= port.wdata;
	end

	always_ff @(posedge core_clk) begin
		rdata_reg <= mem_q[port.raddr];
	end

	assign port.rdata = rdata_reg;
endmodule
`default_nettype wire

/* src/acgt_top.sv */
// Functional notes
// R1 - Inching on an inching axis gives 401
// R2 - Basic/home parameter update while operating gives 471
// R3 - Common parameters update even while operating
// R4 - Operating-data update while operating gives 472
// R5 - Teaching while operating gives 461 or 463
// R6 - Operating flag follows axis motion
// R7 - Error flag set on axis error
// R8 - Host picks axis 0 or 1
// R9 - Update writes value into selected item
// R10 - Item selectors 1 to 16 decoded
// R11 - 150 steps, step 0 means current
// R12 - Inching distance taken from command
// R13 - Teaching data loaded first, at most 16
// R14 - Teaching values in two-word slots
// R15 - Taught values go to consecutive steps
// R16 - Method 1 nonvolatile, 0 volatile
// R17 - Host limits nonvolatile teaching count
// R18 - Target 0 position, 1 speed only
// R19 - At most 16 teaching steps
// R20 - Host writes teaching data as words
// R21 - Rejected command changes no stored data
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module acgt_top
	import acgt_pkg::*;
#(
	parameter int STEPS = NUM_STEPS
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  axis_moving,
	input  wire logic [1:0]  axis_inching,
	input  wire logic [1:0]  axis_fault,
	output logic      [1:0]  operating,
	output logic      [1:0]  error_flag,
	output logic      [1:0]  nv_store,
	output logic      [31:0] inching_move_cmd_distance_0,
	output logic      [31:0] inching_move_cmd_distance_1
);
	localparam int MEM_AW = 13;
	// The memory and its address map are sized for NUM_STEPS per axis
	if (STEPS < 1 || STEPS > NUM_STEPS) begin : g_bad_steps
		$error("step count out of range");
	end
	// ****************************************
	// Bus decode
	// ****************************************
	typedef enum {ST_IDLE, ST_TEACH, ST_READ} acgt_state_e;
	acgt_state_e state_reg;

	logic        wr_en;
	logic        rd_en;
	logic [31:0] arg0_reg;
	logic [31:0] arg1_reg;
	logic [31:0] data_reg;
	logic [31:0] rd_data_reg;
	logic [31:0] nv_count_reg;
	logic [31:0] teach_reg [NUM_TEACH];
	logic [15:0] err_code_reg [NUM_AXES];
	logic [1:0]  err_flag_reg;
	logic [1:0]  oper_reg;
	logic [1:0]  inching_move_cmd_reg;
	logic [STEP_W-1:0] cur_step_reg [NUM_AXES];
	logic [31:0] inching_move_cmd_dist_reg [NUM_AXES];
	logic [31:0] param_reg [NUM_AXES][NUM_PARAMS];
	logic [31:0] common_reg [NUM_PARAMS];
	logic [4:0]  tcnt_reg;
	logic [4:0]  tidx_reg;
	logic [STEP_W-1:0] tstep_reg;
	logic        taxis_reg;
	logic        ttarget_reg;

	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = (state_reg == ST_IDLE);
	assign pslverr = 1'b0;
	// ****************************************
	// Command decode
	// ****************************************
	logic              cmd_go;
	logic [3:0]        op;
	logic              ax;
	logic [4:0]        item;
	logic [STEP_W-1:0] step_sel;
	logic [STEP_W-1:0] step_eff;
	logic [4:0]        t_cnt;
	logic [STEP_W-1:0] t_first;
	logic              busy;
	logic [15:0]       rej_code;
	logic              range_bad;

	assign cmd_go   = wr_en && pready && paddr == OFS_CMD;
	assign op       = pwdata[CMD_OP_LSB +: 4];
	assign ax       = pwdata[CMD_AXIS_BIT];
	assign item     = pwdata[CMD_ITEM_LSB +: ITEM_W];
	assign step_sel = pwdata[CMD_STEP_LSB +: STEP_W];
	assign step_eff = (step_sel == '0) ? cur_step_reg[ax] : step_sel; // R11
	assign t_cnt    = arg0_reg[ARG_CNT_LSB +: 5];
	assign t_first  = arg0_reg[ARG_FIRST_LSB +: STEP_W];
	assign busy     = oper_reg[ax];

	always_comb begin
		rej_code  = ERR_NONE;
		range_bad = 1'b0;
		unique case (op)
			OP_INCHING_MOVE_CMD: begin
				if (inching_move_cmd_reg[ax])
					rej_code = ERR_INCHING_MOVE_CMD_BUSY; // R1
			end
			OP_BASIC, OP_HOMEMAN: begin
				if (busy)
					rej_code = ERR_PARAM_BUSY; // R2
			end
			OP_OPDATA: begin
				range_bad = item == '0 || item > 5'(NUM_ITEMS) || step_sel > STEP_W'(STEPS); // R10
				if (busy)
					rej_code = ERR_OPD_BUSY; // R4
				else if (range_bad)
					rej_code = ERR_RANGE;
			end
			OP_TEACH: begin
				range_bad = t_cnt == '0 || t_cnt > 5'(NUM_TEACH) || t_first == '0 ||
					(9'(t_first) + 9'(t_cnt) - 9'd1) > 9'(STEPS); // R19
				if (busy)
					rej_code = arg0_reg[ARG_TARGET_BIT] ? ERR_TSPD_BUSY : ERR_TPOS_BUSY; // R5
				else if (range_bad)
					rej_code = ERR_RANGE;
			end
			default: rej_code = ERR_NONE;
		endcase
	end
	logic accept;
	assign accept = cmd_go && rej_code == ERR_NONE;
	// ****************************************
	// Memory
	// ****************************************
	acgt_mem_if #(.AW(MEM_AW), .DW(DATA_W)) mif ();
	acgt_opdata_mem #(.DEPTH(NUM_AXES * NUM_STEPS * NUM_ITEMS), .AW(MEM_AW), .DW(DATA_W)) u_mem (
		.core_clk (core_clk),
		.port     (mif.mem)
	);

	function automatic logic [MEM_AW-1:0] maddr(input logic a, input logic [STEP_W-1:0] s,
		input logic [4:0] it);
		maddr = MEM_AW'((int'(a) * NUM_STEPS + int'(s) - 1) * NUM_ITEMS + int'(it) - 1);
	endfunction

	always_comb begin
		mif.we    = 1'b0;
		mif.waddr = '0;
		mif.wdata = data_reg;
		mif.raddr = maddr(ax, step_eff, item);
		if (state_reg == ST_TEACH) begin
			mif.we    = 1'b1; // R15
			mif.waddr = maddr(taxis_reg, tstep_reg, ttarget_reg ? ITEM_SPEED : ITEM_POSITION); // R18
			mif.wdata = teach_reg[tidx_reg[3:0]];
		end else if (accept && op == OP_OPDATA) begin
			mif.we    = 1'b1; // R9 R21
			mif.waddr = maddr(ax, step_eff, item);
		end
	end
	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg   <= ST_IDLE;
			tcnt_reg    <= '0;
			tidx_reg    <= '0;
			tstep_reg   <= '0;
			taxis_reg   <= 1'b0;
			ttarget_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (accept && op == OP_TEACH) begin
						state_reg   <= ST_TEACH;
						tcnt_reg    <= t_cnt;
						tidx_reg    <= '0;
						tstep_reg   <= t_first;
						taxis_reg   <= ax;
						ttarget_reg <= arg0_reg[ARG_TARGET_BIT];
					end else if (accept && op == OP_READ)
						state_reg <= ST_READ;
				end
				ST_TEACH: begin
					tidx_reg  <= tidx_reg + 5'd1;
					tstep_reg <= tstep_reg + STEP_W'(1); // R15
					if (tidx_reg + 5'd1 == tcnt_reg)
						state_reg <= ST_IDLE;
				end
				ST_READ: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			nv_store <= '0;
		else begin
			nv_store <= '0;
			if (state_reg == ST_TEACH && tidx_reg + 5'd1 == tcnt_reg && arg0_reg[ARG_METHOD_BIT])
				nv_store[taxis_reg] <= 1'b1; // R16
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			nv_count_reg <= '0;
		else if (state_reg == ST_TEACH && tidx_reg + 5'd1 == tcnt_reg && arg0_reg[ARG_METHOD_BIT])
			nv_count_reg <= nv_count_reg + 32'd1;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			rd_data_reg <= '0;
		else if (state_reg == ST_READ)
			rd_data_reg <= mif.rdata;
	end
	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			arg0_reg <= '0;
			arg1_reg <= '0;
			data_reg <= '0;
		end else if (wr_en && pready) begin
			if (paddr == OFS_ARG0)
				arg0_reg <= pwdata;
			if (paddr == OFS_ARG1)
				arg1_reg <= pwdata;
			if (paddr == OFS_DATA)
				data_reg <= pwdata;
		end
	end

	for (genvar i = 0; i < NUM_TEACH; i++) begin : g_teach
		always_ff @(posedge core_clk) begin
			if (!rst_n)
				teach_reg[i] <= '0;
			else if (wr_en && pready && paddr == OFS_TEACH_BASE + 12'(8 * i)) // R14
				teach_reg[i] <= pwdata;
		end
	end

	for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				err_code_reg[a]  <= ERR_NONE;
				inching_move_cmd_dist_reg[a] <= '0;
				cur_step_reg[a]  <= STEP_W'(1);
				for (int p = 0; p < NUM_PARAMS; p++)
					param_reg[a][p] <= '0;
			end else if (cmd_go && ax == a) begin
				if (rej_code != ERR_NONE)
					err_code_reg[a] <= rej_code; // R21
				else if (op == OP_CLR_ERR)
					err_code_reg[a] <= ERR_NONE;
				else if (op == OP_INCHING_MOVE_CMD)
					inching_move_cmd_dist_reg[a] <= data_reg; // R12
				else if (op == OP_BASIC || op == OP_HOMEMAN)
					param_reg[a][{op == OP_HOMEMAN, item[2:0]}] <= data_reg; // R9
				else if (op == OP_OPDATA && step_sel != '0)
					cur_step_reg[a] <= step_sel;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int p = 0; p < NUM_PARAMS; p++)
				common_reg[p] <= '0;
		end else if (accept && op == OP_COMMON)
			common_reg[item[3:0]] <= data_reg; // R3
	end
	// ****************************************
	// Axis status
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			oper_reg     <= '0;
			inching_move_cmd_reg     <= '0;
			err_flag_reg <= '0;
		end else begin
			oper_reg <= axis_moving | axis_inching; // R6
			inching_move_cmd_reg <= axis_inching;
			for (int a = 0; a < NUM_AXES; a++) begin
				if (axis_fault[a] || (cmd_go && ax == a && rej_code != ERR_NONE))
					err_flag_reg[a] <= 1'b1; // R7
				else if (cmd_go && ax == a && op == OP_CLR_ERR)
					err_flag_reg[a] <= 1'b0;
			end
		end
	end

	assign operating       = oper_reg;
	assign error_flag      = err_flag_reg;
	assign inching_move_cmd_distance_0 = inching_move_cmd_dist_reg[0];
	assign inching_move_cmd_distance_1 = inching_move_cmd_dist_reg[1];
	// ****************************************
	// Read mux
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			prdata <= '0;
		else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFS_ARG0:    prdata <= arg0_reg;
				OFS_ARG1:    prdata <= arg1_reg;
				OFS_DATA:    prdata <= data_reg;
				OFS_STATUS0: prdata <= {13'h0000, inching_move_cmd_reg[0], oper_reg[0], err_flag_reg[0], err_code_reg[0]};
				OFS_STATUS1: prdata <= {13'h0000, inching_move_cmd_reg[1], oper_reg[1], err_flag_reg[1], err_code_reg[1]};
				OFS_MOTION:  prdata <= {28'h0000000, err_flag_reg, oper_reg};
				OFS_INCH0:   prdata <= inching_move_cmd_dist_reg[0];
				OFS_INCH1:   prdata <= inching_move_cmd_dist_reg[1];
				OFS_RD_DATA: prdata <= rd_data_reg;
				OFS_NV_COUNT: prdata <= nv_count_reg;
				default:     prdata <= '0;
			endcase
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	inching_move_cmd_reject_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
		cmd_go && op == OP_INCHING_MOVE_CMD && inching_move_cmd_reg[ax] |=> err_code_reg[$past(ax)] == ERR_INCHING_MOVE_CMD_BUSY)
		else $error("inching reject missing");
	param_reject_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
		cmd_go && (op == OP_BASIC || op == OP_HOMEMAN) && oper_reg[ax]
		|=> err_code_reg[$past(ax)] == ERR_PARAM_BUSY)
		else $error("parameter reject missing");
	common_ok_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
		cmd_go && op == OP_COMMON |=> common_reg[$past(item[3:0])] == $past(data_reg))
		else $error("common parameter not stored");
	opd_reject_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
		cmd_go && op == OP_OPDATA && oper_reg[ax] |-> !mif.we ##1 err_code_reg[$past(ax)] == ERR_OPD_BUSY)
		else $error("operating data reject missing");
	teach_reject_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
		cmd_go && op == OP_TEACH && oper_reg[ax] |=> state_reg == ST_IDLE &&
		err_code_reg[$past(ax)] == ($past(arg0_reg[ARG_TARGET_BIT]) ? ERR_TSPD_BUSY : ERR_TPOS_BUSY))
		else $error("teaching reject missing");
	oper_track_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
		##1 operating == $past(axis_moving | axis_inching))
		else $error("operating flag wrong");
	err_set_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
		axis_fault != 2'b00 |=> (error_flag & $past(axis_fault)) == $past(axis_fault))
		else $error("error flag not set");
	inching_move_cmd_dist_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
		accept && op == OP_INCHING_MOVE_CMD && ax == 1'b0 |=> inching_move_cmd_distance_0 == $past(data_reg))
		else $error("inching distance not stored");
	teach_len_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
		state_reg == ST_IDLE ##1 state_reg == ST_TEACH |-> ##[1:16] state_reg == ST_IDLE)
		else $error("teaching sequence too long");
	teach_item_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
		state_reg == ST_TEACH |-> mif.waddr[3:0] == (ttarget_reg ? 4'h2 : 4'h0))
		else $error("teaching wrong item");
	teach_cov_c: cover property (@(posedge core_clk) state_reg == ST_TEACH ##1 state_reg == ST_IDLE);
	opd_cov_c: cover property (@(posedge core_clk) accept && op == OP_OPDATA);
	rej_cov_c: cover property (@(posedge core_clk) cmd_go && rej_code != ERR_NONE);
	nv_cov_c: cover property (@(posedge core_clk) nv_store != '0);
endmodule
`default_nettype wire

/* tb/acgt_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acgt_host_model
	import acgt_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	output logic             hang
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		hang = 1'b0;
	end
	// ****************************************
	// APB master transfers
	// ****************************************
	function automatic logic [31:0] cmd(input logic [3:0] op, input logic ax,
		input logic [4:0] it, input logic [7:0] sp);
		cmd = {8'h00, sp, 3'h0, it, 3'h0, ax, op};
	endfunction
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 400);
		q = prdata;
		if (n >= 400) begin
			hang <= 1'b1;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] unused;
		xfer(1'b1, a, d, unused);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask
	// Teaching values go in first, one word into each two-word slot
	task automatic teach_load(input int n, input logic [31:0] base);
		for (int i = 0; i < n && i < 16; i++) begin
			wr(OFS_TEACH_BASE + 12'(8 * i), base + 32'(i));
		end
	endtask
endmodule
`default_nettype wire

/* tb/test_axis_command_gating_teaching.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_axis_command_gating_teaching;
	import acgt_pkg::*;
	logic        core_clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        hang;
	logic [1:0]  axis_moving;
	logic [1:0]  axis_inching;
	logic [1:0]  axis_fault;
	logic [1:0]  operating;
	logic [1:0]  error_flag;
	logic [1:0]  nv_store;
	logic [31:0] inching_move_cmd_distance_0;
	logic [31:0] inching_move_cmd_distance_1;
	logic [31:0] q;
	int          err_count;
	int          n_tests;
	int          nv_cnt;

	acgt_host_model host (.core_clk(core_clk), .pready(pready), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .hang(hang));
	acgt_top #(.STEPS(NUM_STEPS)) DUT (.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.axis_moving(axis_moving), .axis_inching(axis_inching),
		.axis_fault(axis_fault), .operating(operating), .error_flag(error_flag),
		.nv_store(nv_store), .inching_move_cmd_distance_0(inching_move_cmd_distance_0),
		.inching_move_cmd_distance_1(inching_move_cmd_distance_1));

	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (nv_store[0] === 1'b1) begin
			nv_cnt++;
		end
	end
	always @(posedge core_clk) begin
		if (hang === 1'b1) begin
			err_count++;
			end_sim();
		end
	end
	// ****************************************
	// Helpers
	// ****************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic st(input logic ax);
		host.rd(ax ? OFS_STATUS1 : OFS_STATUS0, q);
	endtask
	task automatic do_cmd(input logic [3:0] op, input logic ax, input logic [4:0] it,
		input logic [7:0] sp, input logic [31:0] d);
		host.wr(OFS_DATA, d);
		host.wr(OFS_CMD, host.cmd(op, ax, it, sp));
		cyc(2);
	endtask
	task automatic rdb(input logic ax, input logic [4:0] it, input logic [7:0] sp);
		host.wr(OFS_CMD, host.cmd(OP_READ, ax, it, sp));
		host.rd(OFS_RD_DATA, q);
	endtask
	task automatic clr(input logic ax);
		do_cmd(OP_CLR_ERR, ax, 5'h00, 8'h00, 32'h0);
	endtask
	task automatic teach(input int n, input logic [7:0] first, input logic tg,
		input logic m, input logic [31:0] base);
		host.teach_load(n, base);
		host.wr(OFS_ARG0, {14'h0, m, tg, first, 3'h0, 5'(n)});
		host.wr(OFS_CMD, host.cmd(OP_TEACH, 1'b0, 5'h00, 8'h00));
		cyc(2);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		`CHK("operating", 2'b00, operating);
		`CHK("error_flag", 2'b00, error_flag);
		`CHK("nv_store", 2'b00, nv_store);
		`CHK("pslverr", 1'b0, pslverr);
		host.wr(12'h3fc, 32'hffff_ffff);
		host.rd(12'h3fc, q);
		`CHK("unmapped", 32'h0, q);
		st(1'b0);
		`CHK("status0", 32'h0, q);
		$display("test reset done");
	endtask
	task automatic t_inching_move_cmd();
		do_cmd(OP_INCHING_MOVE_CMD, 1'b0, 5'h00, 8'h00, 32'h1234);
		`CHK("inch0", 32'h1234, inching_move_cmd_distance_0);
		axis_inching <= 2'b01;
		cyc(3);
		do_cmd(OP_INCHING_MOVE_CMD, 1'b0, 5'h00, 8'h00, 32'h5555);
		do_cmd(OP_INCHING_MOVE_CMD, 1'b1, 5'h00, 8'h00, 32'h0777);
		`CHK("inch0 kept", 32'h1234, inching_move_cmd_distance_0);
		`CHK("inch1", 32'h0777, inching_move_cmd_distance_1);
		`CHK("err flag", 2'b01, error_flag);
		st(1'b0);
		`CHK("inching_move_cmd code", ERR_INCHING_MOVE_CMD_BUSY, q[15:0]);
		`CHK("inching bit", 1'b1, q[ST_INCHING_MOVE_CMD_BIT]);
		axis_inching <= 2'b00;
		cyc(3);
		clr(1'b0);
		`CHK("err cleared", 2'b00, error_flag);
		$display("test inching done");
	endtask
	task automatic t_param();
		logic [3:0] ops [2];
		ops = '{OP_BASIC, OP_HOMEMAN};
		axis_moving <= 2'b10;
		cyc(3);
		`CHK("operating", 2'b10, operating);
		host.rd(OFS_MOTION, q);
		`CHK("motion", 4'b0010, q[3:0]);
		for (int i = 0; i < 2; i++) begin
			do_cmd(ops[i], 1'b1, 5'h02, 8'h00, 32'h42);
			st(1'b1);
			`CHK("param code", ERR_PARAM_BUSY, q[15:0]);
			`CHK("oper bit", 1'b1, q[ST_OPER_BIT]);
			clr(1'b1);
		end
		do_cmd(OP_COMMON, 1'b1, 5'h02, 8'h00, 32'h43);
		`CHK("common ok", 2'b00, error_flag);
		axis_moving <= 2'b00;
		cyc(3);
		`CHK("idle", 2'b00, operating);
		$display("test param done");
	endtask
	task automatic t_opdata();
		for (int i = 1; i <= 16; i++) begin
			do_cmd(OP_OPDATA, 1'b0, 5'(i), 8'd150, 32'h100 + 32'(i));
		end
		for (int i = 1; i <= 16; i++) begin
			rdb(1'b0, 5'(i), 8'd150);
			`CHK("opdata item", 32'h100 + 32'(i), q);
		end
		do_cmd(OP_OPDATA, 1'b0, 5'h04, 8'h00, 32'habcd);
		rdb(1'b0, 5'h04, 8'd150);
		`CHK("current step", 32'habcd, q);
		axis_moving <= 2'b01;
		cyc(3);
		do_cmd(OP_OPDATA, 1'b0, 5'h04, 8'd150, 32'h9999);
		st(1'b0);
		`CHK("opdata code", ERR_OPD_BUSY, q[15:0]);
		axis_moving <= 2'b00;
		cyc(3);
		clr(1'b0);
		do_cmd(OP_OPDATA, 1'b0, 5'h04, 8'd151, 32'h9999);
		st(1'b0);
		`CHK("step range", ERR_RANGE, q[15:0]);
		clr(1'b0);
		rdb(1'b0, 5'h04, 8'd150);
		`CHK("opdata kept", 32'habcd, q);
		$display("test opdata done");
	endtask
	task automatic t_teach();
		logic [15:0] codes [2];
		codes = '{ERR_TPOS_BUSY, ERR_TSPD_BUSY};
		for (int i = 7; i <= 9; i++) begin
			do_cmd(OP_OPDATA, 1'b0, ITEM_SPEED, 8'(i), 32'h77);
		end
		teach(3, 8'd7, 1'b0, 1'b1, 32'h1000);
		for (int i = 0; i < 3; i++) begin
			rdb(1'b0, ITEM_POSITION, 8'(7 + i));
			`CHK("taught pos", 32'h1000 + 32'(i), q);
		end
		rdb(1'b0, ITEM_SPEED, 8'd7);
		`CHK("speed kept", 32'h77, q);
		`CHK("nv pulse", 1, nv_cnt);
		host.rd(OFS_NV_COUNT, q);
		`CHK("nv count", 32'h1, q);
		`CHK("nv budget", 1'b1, q < 32'h0001_86a0);
		teach(16, 8'd20, 1'b1, 1'b0, 32'h2000);
		for (int i = 0; i < 16; i++) begin
			rdb(1'b0, ITEM_SPEED, 8'(20 + i));
			`CHK("taught spd", 32'h2000 + 32'(i), q);
		end
		`CHK("no nv pulse", 1, nv_cnt);
		axis_moving <= 2'b01;
		cyc(3);
		for (int t = 0; t < 2; t++) begin
			teach(2, 8'd7, 1'(t), 1'b0, 32'h3000);
			st(1'b0);
			`CHK("teach code", codes[t], q[15:0]);
			clr(1'b0);
		end
		axis_moving <= 2'b00;
		cyc(3);
		teach(17, 8'd7, 1'b0, 1'b0, 32'h4000);
		st(1'b0);
		`CHK("count range", ERR_RANGE, q[15:0]);
		clr(1'b0);
		rdb(1'b0, ITEM_POSITION, 8'd7);
		`CHK("teach kept", 32'h1000, q);
		$display("test teach done");
	endtask
	task automatic t_fault();
		axis_fault <= 2'b10;
		cyc(3);
		`CHK("fault flag", 2'b10, error_flag);
		clr(1'b1);
		`CHK("fault holds", 2'b10, error_flag);
		axis_fault <= 2'b00;
		cyc(2);
		clr(1'b1);
		`CHK("fault cleared", 2'b00, error_flag);
		$display("test fault done");
	endtask

	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		axis_moving = 2'b00;
		axis_inching = 2'b00;
		axis_fault = 2'b00;
		err_count = 0;
		n_tests = 0;
		nv_cnt = 0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		cyc(1);
		t_reset();
		t_inching_move_cmd();
		t_param();
		t_opdata();
		t_teach();
		t_fault();
		end_sim();
	end
endmodule
`default_nettype wire
